//--- hdl/interrupt_priority_trap_control.sv
// Purpose: priority registers, level/vector report and trap control flags
// Assumes: event inputs come from logic on pclk, one-cycle pulses
// Notes: apb slave, zero wait states once the setup cycle has been seen
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module interrupt_priority_trap_control #(
  parameter int ADDR_W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic acc_a_overflow_evt,
  input wire logic acc_b_overflow_evt,
  input wire logic acc_a_catastrophic_evt,
  input wire logic acc_b_catastrophic_evt,
  input wire logic invalid_shift_evt,
  input wire logic divide_by_zero_evt,
  input wire logic dma_error_evt,
  input wire logic address_fault_evt,
  input wire logic stack_fault_evt,
  input wire logic oscillator_fail_evt,
  input wire logic [intc_pkg::LEVEL_W-1:0] cpu_level,
  input wire logic [intc_pkg::VEC_W-1:0] cpu_vector,
  output logic nesting_disable,
  output logic math_trap,
  output logic irq,
  output logic [intc_pkg::N_PRIO*intc_pkg::REG_W-1:0] priority_flat
);
  import intc_pkg::*;

  // index plus two byte bits must fit the address bus
  generate
    if (ADDR_W < IDX_W + 2) begin : g_bad_addr_w
      $error("ADDR_W too small for the register index range");
    end
  endgenerate

  logic [REG_W-1:0] prio_ff [N_PRIO];
  logic [REG_W-1:0] ctrl_ff;
  logic [REG_W-1:0] nxt_ctrl;
  logic [REG_W-1:0] level_vec_ff;
  logic [ST_W-1:0] tstat_ff;
  logic [ST_W-1:0] nxt_tstat;
  logic [ST_W-1:0] tmask_ff;
  logic [ST_W-1:0] nxt_tmask;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic loaded_ff;
  logic math_trap_ff;
  logic irq_ff;
  logic [31:0] rd_word;
  logic rd_err;
  logic access;
  logic wr_en;
  logic aligned;
  logic [IDX_W-1:0] idx;
  logic [REG_W-1:0] wmask;
  logic [REG_W-1:0] set_bits;
  logic [ST_W-1:0] st_set;
  logic ova_hit;
  logic ovb_hit;
  logic cova_hit;
  logic covb_hit;
  logic math_hit;

  // apb decode; pready only after the setup cycle loaded read data
  assign idx = paddr[IDX_W+1:2];
  // shift rather than slice: with the minimum bus width no upper bits exist
  assign aligned = (paddr[1:0] == 2'b00) && ((paddr >> (IDX_W + 2)) == '0);
  assign pready = ce & loaded_ff;
  assign access = psel & penable & pready;
  assign wr_en = access & pwrite & ~pslverr_ff;
  assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign prdata = prdata_ff;
  assign pslverr = pready & pslverr_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded_ff <= 1'b0;
    end else if (ce) begin
      loaded_ff <= psel & ~(penable & loaded_ff);
    end
  end

  // read data captured at setup so that prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (ce && psel && !loaded_ff) begin
      prdata_ff <= rd_word;
      pslverr_ff <= rd_err;
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_err = 1'b1;
    for (int i = 0; i < N_PRIO; i++) begin
      if (idx == PRIO_IDX[i]) begin
        rd_word[REG_W-1:0] = prio_ff[i];
        rd_err = 1'b0;
      end
    end
    if (idx == LEVEL_VEC_IDX) begin
      rd_word[REG_W-1:0] = level_vec_ff;
      rd_err = 1'b0;
    end
    if (idx == CTRL_IDX) begin
      rd_word[REG_W-1:0] = ctrl_ff;
      rd_err = 1'b0;
    end
    if (idx == TSTAT_IDX) begin
      rd_word[ST_W-1:0] = tstat_ff;
      rd_err = 1'b0;
    end
    if (idx == TMASK_IDX) begin
      rd_word[ST_W-1:0] = tmask_ff;
      rd_err = 1'b0;
    end
    if (!aligned) begin
      rd_word = 32'h0000_0000;
      rd_err = 1'b1;
    end
  end

  // priority registers: only implemented 3-bit fields hold state
  genvar g;
  generate
    for (g = 0; g < N_PRIO; g++) begin : g_prio
      logic [REG_W-1:0] impl;
      for (genvar n = 0; n < REG_W / 4; n++) begin : g_nib
        assign impl[n*4+3:n*4] = (PRIO_RST[g][n*4+3:n*4] != 4'h0) ? PRIO_FIELD_MASK : 4'h0;
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          prio_ff[g] <= PRIO_RST[g];
        end else if (ce && wr_en && idx == PRIO_IDX[g]) begin
          prio_ff[g] <= (prio_ff[g] & ~(wmask & impl)) | (pwdata[REG_W-1:0] & wmask & impl);
        end
      end
      assign priority_flat[g*REG_W +: REG_W] = prio_ff[g];
      a_prio_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (prio_ff[g] & ~impl) == '0)
        else $error("unimplemented priority bit set");
    end
  endgenerate

  // trap causes; the single catastrophic enable serves both accumulators
  assign ova_hit = acc_a_overflow_evt & ctrl_ff[ACC_A_OVERFLOW_TRAP_EN_BIT];
  assign ovb_hit = acc_b_overflow_evt & ctrl_ff[ACC_B_OVERFLOW_TRAP_EN_BIT];
  assign cova_hit = acc_a_catastrophic_evt & ctrl_ff[CATASTROPHIC_TRAP_EN_BIT];
  assign covb_hit = acc_b_catastrophic_evt & ctrl_ff[CATASTROPHIC_TRAP_EN_BIT];
  assign math_hit = ova_hit | ovb_hit | cova_hit | covb_hit
                  | invalid_shift_evt | divide_by_zero_evt;

  always_comb begin
    set_bits = '0;
    set_bits[OVA_BIT] = ova_hit;
    set_bits[OVB_BIT] = ovb_hit;
    set_bits[COVA_BIT] = cova_hit;
    set_bits[COVB_BIT] = covb_hit;
    set_bits[SHIFT_BIT] = invalid_shift_evt;
    set_bits[DIV0_BIT] = divide_by_zero_evt;
    set_bits[DMA_BIT] = dma_error_evt;
    set_bits[MATH_BIT] = math_hit;
    set_bits[ADDR_BIT] = address_fault_evt;
    set_bits[STACK_BIT] = stack_fault_evt;
    set_bits[OSC_BIT] = oscillator_fail_evt;
  end

  // software write merges first, hardware set wins so no event is lost
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_en && idx == CTRL_IDX) begin
      nxt_ctrl = (ctrl_ff & ~(wmask & CTRL_WMASK)) | (pwdata[REG_W-1:0] & wmask & CTRL_WMASK);
    end
    nxt_ctrl = nxt_ctrl | set_bits;
    nxt_ctrl[0] = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RST;
    end else if (ce) begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  assign nesting_disable = ctrl_ff[NESTING_DISABLE_BIT];

  // one-cycle trap request to the core for any accepted math cause
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      math_trap_ff <= 1'b0;
    end else if (ce) begin
      math_trap_ff <= math_hit;
    end
  end
  assign math_trap = math_trap_ff;

  // level and vector follow the core; the register ignores writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_vec_ff <= LEVEL_VEC_RST;
    end else if (ce) begin
      level_vec_ff <= '0;
      level_vec_ff[LEVEL_LSB +: LEVEL_W] <= cpu_level;
      level_vec_ff[VEC_LSB +: VEC_W] <= cpu_vector;
    end
  end

  // sticky interrupt status, write one to clear, set wins
  always_comb begin
    st_set = '0;
    st_set[ST_MATH] = math_hit;
    st_set[ST_DMA] = dma_error_evt;
    st_set[ST_ADDR] = address_fault_evt;
    st_set[ST_STACK] = stack_fault_evt;
    st_set[ST_OSC] = oscillator_fail_evt;
    nxt_tstat = tstat_ff;
    if (wr_en && idx == TSTAT_IDX) begin
      nxt_tstat = tstat_ff & ~(pwdata[ST_W-1:0] & wmask[ST_W-1:0]);
    end
    nxt_tstat = nxt_tstat | st_set;
    nxt_tmask = tmask_ff;
    if (wr_en && idx == TMASK_IDX) begin
      nxt_tmask = (tmask_ff & ~wmask[ST_W-1:0]) | (pwdata[ST_W-1:0] & wmask[ST_W-1:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tstat_ff <= TSTAT_RST;
      tmask_ff <= TMASK_RST;
      irq_ff <= 1'b0;
    end else if (ce) begin
      tstat_ff <= nxt_tstat;
      tmask_ff <= nxt_tmask;
      irq_ff <= |(nxt_tstat & nxt_tmask);
    end
  end
  assign irq = irq_ff;

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic ctrl_wr;
  assign ctrl_wr = wr_en && idx == CTRL_IDX;

  a_nest_follows_bit: assert property (ctrl_wr && wmask[NESTING_DISABLE_BIT]
    |=> nesting_disable == $past(pwdata[NESTING_DISABLE_BIT]))
    else $error("nesting disable output does not follow the written bit");

  a_ova_sets_flag: assert property (ce && acc_a_overflow_evt && ctrl_ff[ACC_A_OVERFLOW_TRAP_EN_BIT]
    |=> ctrl_ff[OVA_BIT] && ctrl_ff[MATH_BIT] && math_trap)
    else $error("enabled overflow a did not set flag and trap");

  a_ovb_disabled: assert property (ce && !ctrl_ff[ACC_B_OVERFLOW_TRAP_EN_BIT] && !ctrl_ff[OVB_BIT] && !ctrl_wr
    |=> !ctrl_ff[OVB_BIT])
    else $error("overflow b flag set while its trap is disabled");

  a_cov_shared_en: assert property (ce && acc_b_catastrophic_evt && ctrl_ff[CATASTROPHIC_TRAP_EN_BIT]
    |=> ctrl_ff[COVB_BIT])
    else $error("catastrophic b not trapped under shared enable");

  a_cov_no_event: assert property (ce && !acc_a_catastrophic_evt && !ctrl_ff[COVA_BIT] && !ctrl_wr
    |=> !ctrl_ff[COVA_BIT])
    else $error("catastrophic a flag set with no cause");

  a_shift_math: assert property (ce && invalid_shift_evt
    |=> ctrl_ff[SHIFT_BIT] && ctrl_ff[MATH_BIT] && math_trap)
    else $error("invalid shift did not flag a math trap");

  a_div0_flag: assert property (ce && divide_by_zero_evt |=> ctrl_ff[DIV0_BIT])
    else $error("divide by zero not flagged");

  a_dma_flag: assert property (ce && dma_error_evt |=> ctrl_ff[DMA_BIT] && tstat_ff[ST_DMA])
    else $error("dma error not flagged");

  a_flag_sticky: assert property (ctrl_ff[OVA_BIT] && !ctrl_wr |=> ctrl_ff[OVA_BIT])
    else $error("overflow flag dropped without a write");

  a_math_needs_cause: assert property ($rose(ctrl_ff[MATH_BIT]) && !$past(ctrl_wr)
    |-> $past(math_hit))
    else $error("math flag rose without a math trap");

  a_bit0_zero: assert property (ctrl_ff[0] == 1'b0 && !prdata_ff[16])
    else $error("unimplemented control bit set");

  a_level_layout: assert property (ce |=> level_vec_ff[LEVEL_LSB +: LEVEL_W] == $past(cpu_level)
    && level_vec_ff[15:12] == 4'h0 && level_vec_ff[7] == 1'b0)
    else $error("level register layout broken");

  a_irq_level: assert property (irq == |(tstat_ff & tmask_ff))
    else $error("interrupt output disagrees with status and mask");

  c_overflow_trap: cover property (ce && ova_hit ##1 math_trap);
  c_clear_race: cover property (ctrl_wr && |set_bits);
  c_irq_raised: cover property ($rose(irq));
  c_catastrophic_both: cover property (ce && cova_hit && covb_hit);

endmodule // interrupt_priority_trap_control
`default_nettype wire

//--- shared/intc_pkg.sv
// Purpose: constants for the interrupt priority and trap control block
// Assumes: apb register index times four gives the byte address
// Notes: Functional notes below
`default_nettype none
package intc_pkg;
  localparam int N_PRIO = 13;
  localparam int REG_W = 16;
  localparam int IDX_W = 8;
  localparam logic [IDX_W-1:0] PRIO_IDX [N_PRIO] = '{
    8'hc0, 8'hc4, 8'hc6, 8'hc8, 8'hcc, 8'hce, 8'hd2,
    8'hd4, 8'hd6, 8'hd8, 8'hda, 8'hdc, 8'hde};
  localparam logic [REG_W-1:0] PRIO_RST [N_PRIO] = '{
    16'h0440, 16'h0440, 16'h0400, 16'h4040, 16'h4440, 16'h0044, 16'h4400,
    16'h4444, 16'h4444, 16'h0044, 16'h4400, 16'h4444, 16'h0044};
  localparam logic [3:0] PRIO_FIELD_MASK = 4'h7;
  localparam logic [IDX_W-1:0] LEVEL_VEC_IDX = 8'he0;
  localparam logic [IDX_W-1:0] CTRL_IDX = 8'he2;
  localparam logic [IDX_W-1:0] TSTAT_IDX = 8'he4;
  localparam logic [IDX_W-1:0] TMASK_IDX = 8'he6;
  localparam logic [REG_W-1:0] LEVEL_VEC_RST = 16'h0000;
  localparam logic [REG_W-1:0] CTRL_RST = 16'h0000;
  localparam logic [REG_W-1:0] CTRL_WMASK = 16'hfffe;
  localparam int LEVEL_LSB = 8;
  localparam int LEVEL_W = 4;
  localparam int VEC_LSB = 0;
  localparam int VEC_W = 7;
  localparam int NESTING_DISABLE_BIT = 15;
  localparam int OVA_BIT = 14;
  localparam int OVB_BIT = 13;
  localparam int COVA_BIT = 12;
  localparam int COVB_BIT = 11;
  localparam int ACC_A_OVERFLOW_TRAP_EN_BIT = 10;
  localparam int ACC_B_OVERFLOW_TRAP_EN_BIT = 9;
  localparam int CATASTROPHIC_TRAP_EN_BIT = 8;
  localparam int SHIFT_BIT = 7;
  localparam int DIV0_BIT = 6;
  localparam int DMA_BIT = 5;
  localparam int MATH_BIT = 4;
  localparam int ADDR_BIT = 3;
  localparam int STACK_BIT = 2;
  localparam int OSC_BIT = 1;
  localparam int ST_W = 5;
  localparam int ST_MATH = 0;
  localparam int ST_DMA = 1;
  localparam int ST_ADDR = 2;
  localparam int ST_STACK = 3;
  localparam int ST_OSC = 4;
  localparam logic [ST_W-1:0] TSTAT_RST = 5'h00;
  localparam logic [ST_W-1:0] TMASK_RST = 5'h00;
endpackage
`default_nettype wire

//--- bench/core_periph_model.sv
// Purpose: stands in for the core and the peripherals that raise traps
// Assumes: events are single-cycle pulses on pclk
// Notes: level and vector are held until changed, as the core would
`timescale 1ns/10ps
`default_nettype none
module core_periph_model (
  input wire logic pclk,
  output logic [9:0] evt,
  output logic [intc_pkg::LEVEL_W-1:0] cpu_level,
  output logic [intc_pkg::VEC_W-1:0] cpu_vector
);
  import intc_pkg::*;
  initial begin
    evt = '0;
    cpu_level = '0;
    cpu_vector = '0;
  end
  // one cycle only: a held level would set the flags again each cycle
  task automatic pulse(input int k);
    @(posedge pclk);
    evt <= 10'h001 << k;
    @(posedge pclk);
    evt <= '0;
  endtask
  task automatic set_lv(input logic [LEVEL_W-1:0] l, input logic [VEC_W-1:0] v);
    @(posedge pclk);
    cpu_level <= l;
    cpu_vector <= v;
  endtask
endmodule // core_periph_model
`default_nettype wire

//--- bench/interrupt_priority_trap_control_tb.sv
// Purpose: register, trap flag and interrupt checks over apb
// Assumes: ce high except in the freeze test, both byte lanes always written
// Notes: read data and error are taken at the edge that samples pready high
`timescale 1ns/10ps
`default_nettype none
module interrupt_priority_trap_control_tb;
  import intc_pkg::*;
  localparam logic [9:0] LV_A = {LEVEL_VEC_IDX, 2'b00};
  localparam logic [9:0] CTRL_A = {CTRL_IDX, 2'b00};
  localparam logic [9:0] ST_A = {TSTAT_IDX, 2'b00};
  localparam logic [9:0] MK_A = {TMASK_IDX, 2'b00};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic nesting_disable, math_trap, irq, ce;
  logic [9:0] paddr, evt;
  logic [31:0] pwdata, prdata;
  logic [LEVEL_W-1:0] cpu_level;
  logic [VEC_W-1:0] cpu_vector;
  logic [N_PRIO*REG_W-1:0] priority_flat;
  logic [15:0] rd, exp;
  int bad_count, checks, cycles, traps, n;
  logic [15:0] en_tbl [10] = '{16'h0400, 16'h0200, 16'h0100, 16'h0100, 16'h0, 16'h0,
    16'h0, 16'h0, 16'h0, 16'h0};
  logic [15:0] flag_tbl [10] = '{16'h4010, 16'h2010, 16'h1010, 16'h0810, 16'h0090,
    16'h0050, 16'h0020, 16'h0008, 16'h0004, 16'h0002};
  core_periph_model model (.pclk(pclk), .evt(evt), .cpu_level(cpu_level),
    .cpu_vector(cpu_vector));
  interrupt_priority_trap_control dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'h3), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .acc_a_overflow_evt(evt[0]), .acc_b_overflow_evt(evt[1]),
    .acc_a_catastrophic_evt(evt[2]), .acc_b_catastrophic_evt(evt[3]),
    .invalid_shift_evt(evt[4]), .divide_by_zero_evt(evt[5]), .dma_error_evt(evt[6]),
    .address_fault_evt(evt[7]), .stack_fault_evt(evt[8]), .oscillator_fail_evt(evt[9]),
    .cpu_level(cpu_level), .cpu_vector(cpu_vector), .nesting_disable(nesting_disable),
    .math_trap(math_trap), .irq(irq), .priority_flat(priority_flat));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // counts math_trap cycles too, so a stuck-high pulse shows as an extra count
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (math_trap === 1'b1) begin
      traps <= traps + 1;
    end
    if (cycles == 20000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [9:0] a, input logic [15:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // request stands until the edge that samples pready high
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata[15:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic irq_is(input logic e);
    @(posedge pclk);
    @(negedge pclk);
    check("irq", {15'h0, e}, {15'h0, irq});
  endtask
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    {bad_count, checks, cycles, traps} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < N_PRIO; i++) begin
      xfer(1'b0, {PRIO_IDX[i], 2'b00}, 16'h0);
      check("prio reset", PRIO_RST[i], rd);
      xfer(1'b1, {PRIO_IDX[i], 2'b00}, 16'hffff);
      xfer(1'b0, {PRIO_IDX[i], 2'b00}, 16'h0);
      exp = (PRIO_RST[i] | PRIO_RST[i] >> 1 | PRIO_RST[i] >> 2) & 16'h7777;
      check("prio field", exp, rd);
      check("prio flat", exp, priority_flat[i*REG_W +: REG_W]);
    end
    xfer(1'b0, LV_A, 16'h0);
    check("level reset", LEVEL_VEC_RST, rd);
    xfer(1'b0, CTRL_A, 16'h0);
    check("ctrl reset", CTRL_RST, rd);
    xfer(1'b1, CTRL_A, 16'hffff);
    xfer(1'b0, CTRL_A, 16'h0);
    check("ctrl rw", 16'hfffe, rd);
    check("nesting on", 16'h1, {15'h0, nesting_disable});
    xfer(1'b1, CTRL_A, 16'h0);
    // the write lands at the edge the task returns on; look once it has settled
    @(negedge pclk);
    check("nesting off", 16'h0, {15'h0, nesting_disable});
    model.set_lv(4'hf, 7'h7f);
    xfer(1'b1, LV_A, 16'h0);
    xfer(1'b0, LV_A, 16'h0);
    check("level vector", 16'h0f7f, rd);
    for (int k = 0; k < 10; k++) begin
      if (k < 4) begin
        xfer(1'b1, CTRL_A, 16'h0);
        n = traps;
        model.pulse(k);
        xfer(1'b0, CTRL_A, 16'h0);
        check("ctrl disabled", 16'h0, rd);
        check("trap disabled", 16'(n), 16'(traps));
      end
      xfer(1'b1, CTRL_A, en_tbl[k]);
      n = traps;
      model.pulse(k);
      xfer(1'b0, CTRL_A, 16'h0);
      check("ctrl flags", en_tbl[k] | flag_tbl[k], rd);
      check("trap count", 16'(n + (k < 6)), 16'(traps));
      xfer(1'b0, CTRL_A, 16'h0);
      check("ctrl sticky", en_tbl[k] | flag_tbl[k], rd);
    end
    xfer(1'b0, ST_A, 16'h0);
    check("status", 16'h001f, rd);
    irq_is(1'b0);
    xfer(1'b1, MK_A, 16'h0001);
    irq_is(1'b1);
    xfer(1'b1, ST_A, 16'h0001);
    irq_is(1'b0);
    xfer(1'b0, ST_A, 16'h0);
    check("status w1c", 16'h001e, rd);
    xfer(1'b1, MK_A, 16'h001f);
    irq_is(1'b1);
    xfer(1'b1, ST_A, 16'h001f);
    irq_is(1'b0);
    xfer(1'b0, 10'h3fc, 16'h0);
    check("unmapped err", 16'h1, {15'h0, err});
    check("unmapped data", 16'h0, rd);
    xfer(1'b0, 10'h381, 16'h0);
    check("misaligned err", 16'h1, {15'h0, err});
    // clock enable low: an always-accepted math cause must leave no trace
    @(posedge pclk);
    ce <= 1'b0;
    n = traps;
    model.pulse(4);
    @(posedge pclk);
    ce <= 1'b1;
    xfer(1'b0, CTRL_A, 16'h0);
    check("ctrl frozen", 16'h0002, rd);
    check("trap frozen", 16'(n), 16'(traps));
    close_out();
  end
endmodule // interrupt_priority_trap_control_tb
`default_nettype wire
